/* pkg/acst_defs.vh */
// Constants for the asynchronous chip-select timing block.
// Assumes inclusion by bare name from design files only.
`ifndef ACST_DEFS_VH
`define ACST_DEFS_VH

// Number of chip selects and config field widths
`define ACST_NUM_CS 4
`define ACST_CS_W 2
`define ACST_WAIT_W 4
`define ACST_DIV_W 2

// Divider field encodings
`define ACST_DIV_1 2'h0
`define ACST_DIV_2 2'h1
`define ACST_DIV_4 2'h2
`define ACST_DIV_6 2'h3

// Division ratios, in clock cycles per timing unit
`define ACST_RATIO_1 3'h1
`define ACST_RATIO_2 3'h2
`define ACST_RATIO_4 3'h4
`define ACST_RATIO_6 3'h6

// Fixed extra units: read adds one plus trailing, write adds one plus two
`define ACST_READ_EXTRA 6'h02
`define ACST_WRITE_EXTRA 6'h03

// Requestors and priority retain field
`define ACST_NUM_REQ 5
`define ACST_RETAIN_W 4

`endif

/* core/acst_arbiter.v */
// Shares the memory port among requestors, fair round robin with retain.
// Assumes requests are held until granted and done pulses once per access.
`timescale 1ns/1ps
`default_nettype none
`include "acst_defs.vh"

module acst_arbiter #(
  parameter N = `ACST_NUM_REQ,
  parameter IW = 3,
  parameter RW = `ACST_RETAIN_W
) (
  // Clock and reset
  input wire clock,
  input wire reset,
  // Requests and priority retain counts
  input wire [N-1:0] req,
  input wire [N*RW-1:0] retain,
  // Port state
  input wire port_idle,
  input wire access_done,
  // Grant
  output reg grant_valid,
  output reg [IW-1:0] grant_index
);

  reg [IW-1:0] owner;
  reg [RW-1:0] kept;
  reg [IW-1:0] next_pick;
  reg next_found;
  integer i;
  integer idx;

  always @*
  begin
    next_pick = owner;
    next_found = 1'b0;
    for (i = N; i >= 1; i = i - 1)
    begin
      idx = (owner + i) % N;
      if (req[idx])
      begin
        next_pick = idx[IW-1:0];
        next_found = 1'b1;
      end
    end
  end

  // Owner keeps port while retain allows
  always @*
  begin
    grant_valid = port_idle && (req != {N{1'b0}});
    grant_index = next_pick;
    if (port_idle && req[owner] && (kept < retain[owner*RW +: RW]))
    begin
      grant_index = owner;
    end
    if (!next_found && !req[owner])
    begin
      grant_valid = 1'b0;
    end
  end

  always @(posedge clock)
  begin
    if (reset)
    begin
      owner <= {IW{1'b0}};
      kept <= {RW{1'b0}};
    end
    else if (grant_valid)
    begin
      if (grant_index == owner)
        kept <= kept + 1'b1;
      else
        kept <= {RW{1'b0}};
      owner <= grant_index;
    end
  end

endmodule

`default_nettype wire

/* core/acst_top.v */
// Chip-select timing engine for a slow external asynchronous memory port.
// Assumes config ports are stable while an access on that select runs.
// Function
// - Four chip selects, each own timing config
// - Per-select divider: 1, 2, 4 or 6
// - Read width D*(read_wait+1)+D cycles
// - Write width D*(gap+we_len+1)+2D cycles
// - Write gap wait spaces consecutive writes
// - Write enable held for we_len plus one wait states
// - Fair sharing when no priorities set
// - Priority lets requestor keep port longer
`timescale 1ns/1ps
`default_nettype none
`include "acst_defs.vh"

module acst_top #(
  parameter N = `ACST_NUM_REQ,
  parameter IW = 3,
  parameter NCS = `ACST_NUM_CS,
  parameter WW = `ACST_WAIT_W,
  parameter RW = `ACST_RETAIN_W
) (
  // Clock and reset
  input wire clock,
  input wire reset,
  // Per chip select configuration
  input wire [NCS*`ACST_DIV_W-1:0] cs_clock_divider,
  input wire [NCS*WW-1:0] read_wait,
  input wire [NCS*WW-1:0] write_gap_wait,
  input wire [NCS*WW-1:0] write_enable_len,
  // Priority retain count per requestor
  input wire [N*RW-1:0] priority_retain,
  // Requestors
  input wire [N-1:0] req_valid,
  input wire [N-1:0] req_write,
  input wire [N*`ACST_CS_W-1:0] req_cs,
  output wire [N-1:0] req_grant,
  output reg [N-1:0] req_done,
  // Memory pins
  output reg [NCS-1:0] chip_select_n,
  output reg write_enable_n,
  output reg output_enable_n,
  output reg port_busy
);

  localparam ST_IDLE = 1'b0;
  localparam ST_ACTIVE = 1'b1;

  wire grant_valid;
  wire [IW-1:0] grant_index;
  reg state;
  reg [IW-1:0] cur_req;
  reg cur_write;
  reg [2:0] ratio;
  reg [2:0] pre;
  reg [5:0] units;
  reg [5:0] unit_total;
  reg [5:0] we_start;
  reg [5:0] we_end;
  reg [`ACST_CS_W-1:0] sel_cs;
  reg [`ACST_DIV_W-1:0] sel_div;
  reg [WW-1:0] sel_rd;
  reg [WW-1:0] sel_gap;
  reg [WW-1:0] sel_wel;
  reg [2:0] next_ratio;
  reg [5:0] next_unit_total;
  wire tick;
  wire last;

  acst_arbiter #(
    .N(N),
    .IW(IW),
    .RW(RW)
  ) u_arbiter (
    .clock(clock),
    .reset(reset),
    .req(req_valid),
    .retain(priority_retain),
    .port_idle(state == ST_IDLE),
    .access_done(last),
    .grant_valid(grant_valid),
    .grant_index(grant_index)
  );

  assign req_grant = grant_valid ? ({{(N-1){1'b0}}, 1'b1} << grant_index) : {N{1'b0}};

  always @*
  begin
    sel_cs = req_cs[grant_index*`ACST_CS_W +: `ACST_CS_W];
    sel_div = cs_clock_divider[sel_cs*`ACST_DIV_W +: `ACST_DIV_W];
    sel_rd = read_wait[sel_cs*WW +: WW];
    sel_gap = write_gap_wait[sel_cs*WW +: WW];
    sel_wel = write_enable_len[sel_cs*WW +: WW];
    case (sel_div)
      `ACST_DIV_1: next_ratio = `ACST_RATIO_1;
      `ACST_DIV_2: next_ratio = `ACST_RATIO_2;
      `ACST_DIV_4: next_ratio = `ACST_RATIO_4;
      default: next_ratio = `ACST_RATIO_6;
    endcase
  end

  // One enable pulse per divided unit
  assign tick = (state == ST_ACTIVE) && (pre == ratio - 3'h1);
  assign last = tick && (units == unit_total - 6'h01);

  // Write units: gap plus we_len plus three
  always @*
  begin
    if (req_write[grant_index])
    begin
      next_unit_total = {2'h0, sel_gap} + {2'h0, sel_wel} + `ACST_WRITE_EXTRA;
    end
    else
    begin
      next_unit_total = {2'h0, sel_rd} + `ACST_READ_EXTRA;
    end
  end

  // Prescaler and unit count, cleared while idle
  always @(posedge clock)
  begin
    if (reset)
    begin
      pre <= 3'h0;
      units <= 6'h00;
    end
    else if (state == ST_IDLE)
    begin
      pre <= 3'h0;
      units <= 6'h00;
    end
    else if (tick)
    begin
      pre <= 3'h0;
      units <= units + 6'h01;
    end
    else
    begin
      pre <= pre + 3'h1;
    end
  end

  // Write enable from second unit for we_len plus one units
  always @(posedge clock)
  begin
    if (reset)
    begin
      write_enable_n <= 1'b1;
    end
    else if (last)
    begin
      write_enable_n <= 1'b1;
    end
    else if (tick && cur_write && (units + 6'h01 == we_start))
    begin
      write_enable_n <= 1'b0;
    end
    // Gap units follow write enable release
    else if (tick && (units + 6'h01 == we_end))
    begin
      write_enable_n <= 1'b1;
    end
  end

  always @(posedge clock)
  begin
    if (reset)
    begin
      state <= ST_IDLE;
      cur_req <= {IW{1'b0}};
      cur_write <= 1'b0;
      ratio <= `ACST_RATIO_1;
      unit_total <= 6'h00;
      we_start <= 6'h00;
      we_end <= 6'h00;
      chip_select_n <= {NCS{1'b1}};
      output_enable_n <= 1'b1;
      port_busy <= 1'b0;
      req_done <= {N{1'b0}};
    end
    else
    begin
      req_done <= {N{1'b0}};
      case (state)
        ST_IDLE:
        begin
          if (grant_valid)
          begin
            state <= ST_ACTIVE;
            port_busy <= 1'b1;
            cur_req <= grant_index;
            cur_write <= req_write[grant_index];
            ratio <= next_ratio;
            unit_total <= next_unit_total;
            // Write enable spans we_len plus one units
            we_start <= 6'h01;
            we_end <= {2'h0, sel_wel} + 6'h02;
            chip_select_n <= ~({{(NCS-1){1'b0}}, 1'b1} << sel_cs);
            output_enable_n <= req_write[grant_index];
          end
        end
        ST_ACTIVE:
        begin
          // Release select at end of width
          if (last)
          begin
            state <= ST_IDLE;
            port_busy <= 1'b0;
            chip_select_n <= {NCS{1'b1}};
            output_enable_n <= 1'b1;
            req_done[cur_req] <= 1'b1;
          end
        end
        default:
        begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

endmodule

`default_nettype wire

/* verification/acst_mem_model.sv */
// Memory-side monitor: widths of select and write strobe.
// Assumes the pins of acst_top, sampled on the same clock.
`timescale 1ns/1ps
`default_nettype none
module acst_mem_model (
  // Clock and pins
  input wire logic clock,
  input wire logic [3:0] chip_select_n,
  input wire logic write_enable_n,
  input wire logic output_enable_n,
  // Last widths in cycles, cleared as each select falls
  output logic [7:0] cs_width,
  output logic [7:0] we_width,
  output logic [7:0] oe_width
);
  logic [7:0] cs_count;
  logic [7:0] we_count;
  logic [7:0] oe_count;
  always @(posedge clock)
  begin
    cs_count <= &chip_select_n ? 8'h00 : cs_count + 8'h01;
    we_count <= write_enable_n ? 8'h00 : we_count + 8'h01;
    oe_count <= output_enable_n ? 8'h00 : oe_count + 8'h01;
    if (&chip_select_n && cs_count != 8'h00)
      cs_width <= cs_count;
    if (!(&chip_select_n) && cs_count == 8'h00)
    begin
      cs_width <= 8'h00;
      we_width <= 8'h00;
      oe_width <= 8'h00;
    end
    if (write_enable_n && we_count != 8'h00)
      we_width <= we_count;
    if (output_enable_n && oe_count != 8'h00)
      oe_width <= oe_count;
  end
endmodule
`default_nettype wire

/* verification/acst_top_asserts.sv */
// Checker on the ports of acst_top, bound to every instance.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module acst_top_asserts #(
  parameter N = 5,
  parameter NCS = 4
) (
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // Requestors
  input wire logic [N-1:0] req_grant,
  input wire logic [N-1:0] req_done,
  // Memory pins
  input wire logic [NCS-1:0] chip_select_n,
  input wire logic write_enable_n,
  input wire logic output_enable_n,
  input wire logic port_busy
);
  default clocking @(posedge clock);
  endclocking
  default disable iff (reset);
  a_one_select: assert property ($onehot0(~chip_select_n))
    else $error("select overlap");
  a_one_grant: assert property ($onehot0(req_grant))
    else $error("grant overlap");
  a_grant_idle: assert property (|req_grant |-> !port_busy)
    else $error("grant while busy");
  a_grant_starts: assert property (|req_grant |=> port_busy && !(&chip_select_n))
    else $error("no access after grant");
  a_busy_select: assert property (port_busy == !(&chip_select_n))
    else $error("busy and select differ");
  a_done_release: assert property ($rose(&chip_select_n) == (|req_done))
    else $error("done off release");
  a_read_strobe: assert property (!output_enable_n |-> write_enable_n && !(&chip_select_n))
    else $error("read strobe misplaced");
  a_write_late: assert property ($fell(write_enable_n) |-> !(&$past(chip_select_n)))
    else $error("write strobe early");
endmodule
bind acst_top acst_top_asserts #(.N(N), .NCS(NCS)) u_chk (.*);
`default_nettype wire

/* verification/tb.sv */
// Self-checking bench for acst_top with a memory monitor.
// Assumes a 10 MHz clock and synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin errors++; \
  $display("MISMATCH %0t %h %h", $time, g, e); end end
module tb;
  logic clock = 1'h0;
  logic reset = 1'h1;
  logic [7:0] cs_clock_divider = 8'hE4;
  logic [15:0] read_wait = 16'h3210;
  logic [15:0] write_gap_wait = 16'h0123;
  logic [15:0] write_enable_len = 16'h1021;
  logic [19:0] priority_retain = 20'h0;
  logic [4:0] req_valid = 5'h0;
  logic [4:0] req_write = 5'h0;
  logic [9:0] req_cs = 10'h0;
  wire [4:0] req_grant;
  wire [4:0] req_done;
  wire [3:0] chip_select_n;
  wire write_enable_n;
  wire port_busy;
  wire output_enable_n;
  wire [7:0] cs_width;
  wire [7:0] we_width;
  wire [7:0] oe_width;
  int errors = 0;
  int tests_run = 0;
  initial forever #50 clock = ~clock;
  acst_top u_dut (.*);
  acst_mem_model u_mem (.*);
  task automatic wrap_up();
    $display("%0d compared, %0d mismatched", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic tick();
    @(posedge clock);
    #10;
  endtask
  task automatic await(input int k, input int r);
    for (int n = 0; (k == 0 ? req_grant[r] : k == 1 ? req_done[r] : !port_busy) !== 1'h1; n++)
    begin
      tick();
      if (n > 300)
      begin
        errors++;
        wrap_up();
      end
    end
  endtask
  task automatic access(input int r, input int c, input bit wr);
    int d;
    d = cs_clock_divider[2*c +: 2] == 2'h3 ? 6 : 1 << cs_clock_divider[2*c +: 2];
    req_valid[r] = 1'h1;
    req_write[r] = wr;
    req_cs[2*r +: 2] = 2'(c);
    #1;
    await(0, r);
    tick();
    req_valid[r] = 1'h0;
    await(1, r);
    tick();
    if (wr)
    begin
      `CHK(cs_width, 8'(d * (write_gap_wait[4*c +: 4] + write_enable_len[4*c +: 4] + 3)))
      `CHK(we_width, 8'(d * (write_enable_len[4*c +: 4] + 1)))
      `CHK(oe_width, 8'h00)
    end
    else
    begin
      `CHK(cs_width, 8'(d * (read_wait[4*c +: 4] + 2)))
      `CHK(oe_width, 8'(d * (read_wait[4*c +: 4] + 2)))
      `CHK(we_width, 8'h00)
    end
  endtask
  task automatic t_widths(input bit wr);
    for (int r = 0; r < 5; r++)
      access(r, r % 4, wr);
    $display("widths done, write %0d", wr);
  endtask
  task automatic t_share(input int keep, input int run);
    bit seen[$];
    int best = 0;
    int cur = 0;
    priority_retain[3:0] = 4'(keep);
    req_valid[1:0] = 2'h3;
    repeat (150)
    begin
      tick();
      if (|req_grant[1:0])
        seen.push_back(req_grant[0]);
    end
    req_valid[1:0] = 2'h0;
    await(2, 0);
    foreach (seen[i])
    begin
      cur = seen[i] ? cur + 1 : 0;
      best = cur > best ? cur : best;
    end
    `CHK(best, run)
    $display("sharing done, keep %0d", keep);
  endtask
  initial
  begin
    repeat (16) @(posedge clock);
    #10;
    reset = 1'h0;
    `CHK({req_done, port_busy, chip_select_n, write_enable_n, output_enable_n}, 12'h03F)
    t_widths(1'b0);
    t_widths(1'b1);
    t_share(0, 1);
    t_share(1, 2);
    wrap_up();
  end
endmodule
`undef CHK
`default_nettype wire
